// *** pkg/lvc_pkg.sv ***
// constants and decode helpers for the channel zero register bank
// Functional notes
// - snoop policy bit rejects snooped requests
// - port arbitration capability reads 01h only
// - channel zero enable reads one, ignores writes
// - channel zero identifier fixed zero, read-only
// - writable class map bits 7:1, reset FFh
// - class zero routing bit reads one, read-only
// - registers at fixed offsets from programmed base
package lvc_pkg;
   localparam int          LVC_BLK_AW        = 12;
   // byte offsets inside the block, as mapped from the base
   localparam logic [11:0] LVC_OFF_PVC_CAP2  = 12'h008;
   localparam logic [11:0] LVC_OFF_PVC_CTL   = 12'h00C;
   localparam logic [11:0] LVC_OFF_CH0_CAP   = 12'h010;
   localparam logic [11:0] LVC_OFF_CH0_CTL   = 12'h014;
   localparam logic [11:0] LVC_OFF_CH0_STS   = 12'h01A;
   // the status halfword lives in the upper lanes of this dword
   localparam logic [11:0] LVC_OFF_STS_WORD  = 12'h018;
   localparam int          LVC_STS_LANE_POS  = 16;
   // values after reset
   localparam logic [31:0] LVC_RST_PVC_CAP2  = 32'h00000000;
   localparam logic [15:0] LVC_RST_PVC_CTL   = 16'h0000;
   localparam logic [31:0] LVC_RST_CH0_CAP   = 32'h00000001;
   localparam logic [31:0] LVC_RST_CH0_CTL   = 32'h800000FF;
   localparam logic [15:0] LVC_RST_CH0_STS   = 16'h0002;
   // field positions
   localparam int          LVC_CHANNEL_ARBITRATION_SELECT_LSB      = 1;
   localparam int          LVC_SNOOP_POS     = 15;
   localparam int          LVC_EN_POS        = 31;
   localparam int          LVC_ID_LSB        = 24;
   localparam int          LVC_PAS_LSB       = 17;
   localparam int          LVC_MAP_LSB       = 1;
   localparam int          LVC_NP_POS        = 1;
   localparam logic [7:0]  LVC_PAC_VAL       = LVC_RST_CH0_CAP[7:0];
   localparam logic [2:0]  LVC_ID_VAL        = LVC_RST_CH0_CTL[26:24];
   localparam logic [2:0]  LVC_CHANNEL_ARBITRATION_SELECT_RST      = LVC_RST_PVC_CTL[3:1];
   localparam logic [2:0]  LVC_PAS_RST       = LVC_RST_CH0_CTL[19:17];
   localparam logic [7:0]  LVC_MAP_RST       = LVC_RST_CH0_CTL[7:0];

   // dword that holds a byte offset
   function automatic logic [11:0] lvc_word(input logic [11:0] off);
      lvc_word = {off[11:2], 2'h0};
   endfunction

   // base match against the programmed link register base
   function automatic logic lvc_in_block(input logic [31:0] addr,
                                         input logic [31:0] base);
      lvc_in_block = (addr[31:LVC_BLK_AW] == base[31:LVC_BLK_AW]);
   endfunction
endpackage

// *** rtl/lvc_negot.sv ***
// channel zero negotiation-pending tracker
`timescale 1ns/1ps
module lvc_negot
   import lvc_pkg::*;
(
   input  wire logic i_sys_clk,
   input  wire logic i_nrst,
   input  wire logic i_chan_enable,
   input  wire logic i_dl_down,
   input  wire logic i_fc_init2_done,
   output logic      o_pending
);
   logic pending_r;

   // set wins over clear: a down link in the exit cycle keeps it pending
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         pending_r <= LVC_RST_CH0_STS[LVC_NP_POS];
      end else if (!i_chan_enable || i_dl_down) begin
         pending_r <= 1'b1;
      end else if (i_fc_init2_done) begin
         pending_r <= 1'b0;
      end
   end

   assign o_pending = pending_r;

   a_pend_on_down: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst) i_dl_down |=> pending_r)
      else $error("pending not set after link down");

   a_pend_clears: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      (i_fc_init2_done && i_chan_enable && !i_dl_down) |=> !pending_r)
      else $error("pending not cleared after init exit");

   a_pend_holds: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      (pending_r && !i_fc_init2_done) |=> pending_r)
      else $error("pending cleared without init exit");

   c_pend_clear: cover property (@(posedge i_sys_clk)
      disable iff (!i_nrst) pending_r ##1 !pending_r);
endmodule // lvc_negot

// *** rtl/lvc_regs.sv ***
// channel zero resource register bank with snoop policy and class map
`timescale 1ns/1ps
module lvc_regs
   import lvc_pkg::*;
#(
   parameter logic SNOOP_REJECT = LVC_RST_CH0_CAP[LVC_SNOOP_POS]
)(
   input  wire logic        i_sys_clk,
   input  wire logic        i_nrst,
   input  wire logic [31:0] i_link_register_base,
   input  wire logic [31:0] i_addr,
   input  wire logic        i_rd_en,
   input  wire logic        i_wr_en,
   input  wire logic [3:0]  i_be,
   input  wire logic [31:0] i_wdata,
   output logic      [31:0] o_rdata,
   output logic             o_rd_valid,
   input  wire logic        i_dl_down,
   input  wire logic        i_fc_init2_done,
   input  wire logic        i_req_valid,
   input  wire logic        i_req_no_snoop,
   input  wire logic [2:0]  i_req_tc,
   output logic             o_req_done,
   output logic             o_req_unsupported,
   output logic             o_req_mapped,
   output logic [7:0]       o_traffic_class_map,
   output logic [2:0]       o_port_arbitration_select,
   output logic [2:0]       o_channel_arbitration_select,
   output logic             o_negotiation_pending
);
   ////////////////////////////////////////////////////////////////////////
   logic [2:0]  channel_arbitration_select_r;
   logic [2:0]  pas_r;
   logic [7:0]  map_r;
   logic [31:0] rdata_r;
   logic        rd_valid_r;
   logic [11:0] rd_off_r;
   logic        rd_hit_r;
   logic        req_done_r;
   logic        req_ur_r;
   logic        req_map_r;
   logic        pending;
   logic        hit;
   logic [11:0] off;
   logic [11:0] woff;
   logic [31:0] rdata_nxt;
   logic        chan_enable;

   assign hit  = lvc_in_block(i_addr, i_link_register_base);
   assign off  = i_addr[11:0];
   assign woff = lvc_word(off);
   // channel zero cannot be turned off, so the tracker sees it enabled
   assign chan_enable = LVC_RST_CH0_CTL[LVC_EN_POS];

   ////////////////////////////////////////////////////////////////////////
   // writable fields; reserved and fixed bits have no storage, except map_r bit 0, which is held at one
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         channel_arbitration_select_r <= LVC_CHANNEL_ARBITRATION_SELECT_RST;
      end else if (i_wr_en && hit && woff == LVC_OFF_PVC_CTL && i_be[0]) begin
         channel_arbitration_select_r <= i_wdata[LVC_CHANNEL_ARBITRATION_SELECT_LSB +: 3];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         pas_r <= LVC_PAS_RST;
      end else if (i_wr_en && hit && woff == LVC_OFF_CH0_CTL && i_be[2]) begin
         pas_r <= i_wdata[LVC_PAS_LSB +: 3];
      end
   end

   // bit 0 keeps class zero on channel zero whatever is written
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         map_r <= LVC_MAP_RST;
      end else if (i_wr_en && hit && woff == LVC_OFF_CH0_CTL && i_be[0]) begin
         map_r <= {i_wdata[7:LVC_MAP_LSB], 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; unmapped offsets and outside the block read zero
   always_comb begin
      rdata_nxt = 32'h00000000;
      if (hit) begin
         case (woff)
            LVC_OFF_PVC_CAP2: begin
               rdata_nxt = LVC_RST_PVC_CAP2;
            end
            LVC_OFF_PVC_CTL: begin
               rdata_nxt = {28'h0000000, channel_arbitration_select_r, 1'b0};
            end
            LVC_OFF_CH0_CAP: begin
               rdata_nxt = {16'h0000, SNOOP_REJECT, 7'h00,
                            LVC_PAC_VAL};
            end
            LVC_OFF_CH0_CTL: begin
               rdata_nxt = {1'b1, 4'h0, LVC_ID_VAL, 4'h0, pas_r,
                            9'h000, map_r[7:1], 1'b1};
            end
            LVC_OFF_STS_WORD: begin
               rdata_nxt[LVC_STS_LANE_POS + LVC_NP_POS] = pending;
            end
            default: begin
               rdata_nxt = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         rdata_r    <= 32'h00000000;
         rd_valid_r <= 1'b0;
         rd_off_r   <= 12'h000;
         rd_hit_r   <= 1'b0;
      end else begin
         rd_valid_r <= i_rd_en;
         if (i_rd_en) begin
            rdata_r  <= rdata_nxt;
            rd_off_r <= woff;
            rd_hit_r <= hit;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request policy: a snooped request is refused only when rejecting
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         req_done_r <= 1'b0;
         req_ur_r   <= 1'b0;
         req_map_r  <= 1'b0;
      end else begin
         req_done_r <= i_req_valid;
         req_ur_r   <= i_req_valid && SNOOP_REJECT && !i_req_no_snoop;
         req_map_r  <= i_req_valid && map_r[i_req_tc];
      end
   end

   lvc_negot u_negot (
      .i_sys_clk       (i_sys_clk),
      .i_nrst          (i_nrst),
      .i_chan_enable   (chan_enable),
      .i_dl_down       (i_dl_down),
      .i_fc_init2_done (i_fc_init2_done),
      .o_pending       (pending)
   );

   assign o_rdata                      = rdata_r;
   assign o_rd_valid                   = rd_valid_r;
   assign o_req_done                   = req_done_r;
   assign o_req_unsupported            = req_ur_r;
   assign o_req_mapped                 = req_map_r;
   assign o_traffic_class_map          = map_r;
   assign o_port_arbitration_select    = pas_r;
   assign o_channel_arbitration_select = channel_arbitration_select_r;
   assign o_negotiation_pending        = pending;

   ////////////////////////////////////////////////////////////////////////
   a_snoop_policy: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      i_req_valid |=> (o_req_unsupported == (SNOOP_REJECT &&
                       !$past(i_req_no_snoop))))
      else $error("snoop policy answer wrong");

   a_pac_value: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      (rd_valid_r && rd_hit_r && rd_off_r == LVC_OFF_CH0_CAP)
      |-> o_rdata[7:0] == 8'h01)
      else $error("port arbitration capability wrong");

   a_enable_one: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      (rd_valid_r && rd_hit_r && rd_off_r == LVC_OFF_CH0_CTL)
      |-> o_rdata[31] && o_rdata[0])
      else $error("enable or class zero bit reads zero");

   a_id_zero: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      (rd_valid_r && rd_hit_r && rd_off_r == LVC_OFF_CH0_CTL)
      |-> o_rdata[26:24] == 3'h0 && o_rdata[30:27] == 4'h0)
      else $error("identifier not zero");

   a_map_write: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      (i_wr_en && hit && woff == LVC_OFF_CH0_CTL && i_be[0])
      |=> o_traffic_class_map == {$past(i_wdata[7:1]), 1'b1})
      else $error("class map write lost");

   a_map_reset: assert property (@(posedge i_sys_clk)
      $rose(i_nrst) |-> o_traffic_class_map == 8'hFF)
      else $error("class map reset value wrong");

   a_status_read: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      (rd_valid_r && rd_hit_r && rd_off_r == LVC_OFF_STS_WORD)
      |-> o_rdata[17] == $past(pending) && o_rdata[16] == 1'b0)
      else $error("status bit read wrong");

   a_outside_zero: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      (i_rd_en && !hit) |=> o_rd_valid && o_rdata == 32'h00000000)
      else $error("read outside block not zero");

   a_reserved_zero: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      (rd_valid_r && rd_hit_r && rd_off_r == LVC_OFF_PVC_CTL)
      |-> o_rdata[31:4] == 28'h0000000 && !o_rdata[0])
      else $error("reserved control bits not zero");

   c_map_write: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_wr_en && hit && woff == LVC_OFF_CH0_CTL && i_be[0]);
   c_status_rd: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_rd_en && hit && woff == LVC_OFF_STS_WORD);
   c_req_map: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
      o_req_done && !o_req_mapped);
endmodule // lvc_regs

// *** bench/lvc_hub_model.sv ***
// far-end hub model: link down level and init-done pulse
`timescale 1ns/1ps
module lvc_hub_model (
   input  wire logic i_sys_clk,
   input  wire logic i_nrst,
   input  wire logic i_link_up,
   input  wire logic i_slow,
   output logic      o_dl_down,
   output logic      o_fc_init2_done
);
   logic [3:0] cnt_r;
   ////////////////////////////////////////
   // training time varies so pending is seen to wait on the far end
   always_ff @(posedge i_sys_clk) begin
      o_fc_init2_done <= 1'b0;
      if (!i_nrst || !i_link_up) begin
         cnt_r     <= 4'h0;
         o_dl_down <= 1'b1;
      end else if (o_dl_down) begin
         cnt_r <= cnt_r + 4'h1;
         if (cnt_r == (i_slow ? 4'hC : 4'h2)) begin
            o_dl_down       <= 1'b0;
            o_fc_init2_done <= 1'b1;
         end
      end
   end
endmodule // lvc_hub_model

// *** bench/testbench.sv ***
// self-checking bench for the channel zero register bank
`timescale 1ns/1ps
module testbench
   import lvc_pkg::*;
;
   localparam logic [31:0] BASE = 32'h00045000;
   localparam logic [7:0]  MAP  = 8'h0B;
   logic        clk, nrst, rd_en, wr_en, rqv, rqns, lup, slow;
   logic        rdv, dld, fcd, rqd, rqu, rqm, pend;
   logic        rqd2, rqu2, rqm2;
   logic [3:0]  be;
   logic [2:0]  rqtc, port_arbitration_select, channel_arbitration_select;
   logic [7:0]  tcm;
   logic [31:0] addr, wdata, rdata, rdata2;
   logic [75:0] rows [6];
   int          fail_count, n_checks;

   lvc_regs i_dut (.i_sys_clk(clk), .i_nrst(nrst),
      .i_link_register_base(BASE), .i_addr(addr), .i_rd_en(rd_en),
      .i_wr_en(wr_en), .i_be(be), .i_wdata(wdata), .o_rdata(rdata),
      .o_rd_valid(rdv), .i_dl_down(dld), .i_fc_init2_done(fcd),
      .i_req_valid(rqv), .i_req_no_snoop(rqns), .i_req_tc(rqtc),
      .o_req_done(rqd), .o_req_unsupported(rqu), .o_req_mapped(rqm),
      .o_traffic_class_map(tcm), .o_port_arbitration_select(port_arbitration_select),
      .o_channel_arbitration_select(channel_arbitration_select), .o_negotiation_pending(pend));
   // same bank with snooped requests refused, so the reject path is reached
   lvc_regs #(.SNOOP_REJECT(1'b1)) i_dut_rej (.i_sys_clk(clk),
      .i_nrst(nrst), .i_link_register_base(BASE), .i_addr(addr),
      .i_rd_en(rd_en), .i_wr_en(wr_en), .i_be(be), .i_wdata(wdata),
      .o_rdata(rdata2), .o_rd_valid(), .i_dl_down(dld),
      .i_fc_init2_done(fcd), .i_req_valid(rqv), .i_req_no_snoop(rqns),
      .i_req_tc(rqtc), .o_req_done(rqd2), .o_req_unsupported(rqu2),
      .o_req_mapped(rqm2), .o_traffic_class_map(),
      .o_port_arbitration_select(), .o_channel_arbitration_select(),
      .o_negotiation_pending());
   lvc_hub_model i_hub (.i_sys_clk(clk), .i_nrst(nrst), .i_link_up(lup),
      .i_slow(slow), .o_dl_down(dld), .o_fc_init2_done(fcd));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      @(negedge clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      // the valid pulse stands only in the cycle after the strobe edge
      chk({31'h0, rdv}, 32'h1);
      chk(rdata, exp);
   endtask
   task automatic wr(input logic [31:0] a, input logic [3:0] b,
                     input logic [31:0] d);
      @(negedge clk);
      addr = a;
      be = b;
      wdata = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
   endtask
   task automatic req(input logic [2:0] tc, input logic ns,
                      input logic m);
      @(negedge clk);
      rqtc = tc;
      rqns = ns;
      rqv = 1'b1;
      @(negedge clk);
      rqv = 1'b0;
      chk({29'h0, rqd, rqu, rqm}, {29'h0, 2'b10, m});
      chk({29'h0, rqd2, rqu2, rqm2}, {29'h0, 1'b1, !ns, m});
   endtask
   // bounded wait; running out ends the run as a mismatch
   task automatic wait_pend(input logic v);
      int k;
      for (k = 0; k < 40 && pend !== v; k++)
         @(negedge clk);
      if (pend !== v) begin
         fail_count++;
         finish_test();
      end
   endtask
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #(50 * 20000);
      fail_count++;
      finish_test();
   end
   initial begin
      {nrst, rd_en, wr_en, rqv, rqns, lup, slow} = '0;
      {be, rqtc, addr, wdata} = '0;
      // offset, value after reset, value after writing all ones
      rows = '{{12'h008, 32'h00000000, 32'h00000000},
               {12'h00C, 32'h00000000, 32'h0000000E},
               {12'h010, 32'h00000001, 32'h00000001},
               {12'h014, 32'h800000FF, 32'h800E00FF},
               {12'h018, 32'h00020000, 32'h00020000},
               {12'h01C, 32'h00000000, 32'h00000000}};
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      chk({18'h0, tcm, port_arbitration_select, channel_arbitration_select}, {18'h0, 8'hFF, 6'h0});
      for (int i = 0; i < 6; i++)
         rd(BASE + 32'(rows[i][75:64]), rows[i][63:32]);
      rd(BASE + 32'h10, 32'h00000001);
      chk(rdata2, 32'h00008001);
      for (int i = 0; i < 6; i++)
         wr(BASE + 32'(rows[i][75:64]), 4'hF, 32'hFFFFFFFF);
      for (int i = 0; i < 6; i++)
         rd(BASE + 32'(rows[i][75:64]), rows[i][31:0]);
      chk({18'h0, tcm, port_arbitration_select, channel_arbitration_select}, {18'h0, 8'hFF, 6'h3F});
      wr(BASE + 32'h14, 4'hF, 32'h00000000);
      rd(BASE + 32'h14, 32'h80000001);
      wr(BASE + 32'h14, 4'h2, 32'hFFFFFFFF);
      rd(BASE + 32'h14, 32'h80000001);
      // selects set to one and the class map to 0Bh before traffic
      wr(BASE + 32'h14, 4'h5, 32'h0002000A);
      wr(BASE + 32'hC, 4'h1, 32'h00000002);
      wr(BASE + 32'h1014, 4'hF, 32'h00000000);
      rd(BASE + 32'h1014, 32'h00000000);
      rd(BASE + 32'h14, 32'h8002000B);
      chk({24'h0, tcm}, {24'h0, MAP});
      lup = 1'b1;
      wait_pend(1'b0);
      rd(BASE + 32'h18, 32'h00000000);
      // traffic only once pending is clear at both ends
      for (int i = 0; i < 16; i++)
         req(3'(i), i[3], MAP[3'(i)]);
      lup = 1'b0;
      repeat (3) @(negedge clk);
      chk({31'h0, pend}, 32'h1);
      slow = 1'b1;
      lup = 1'b1;
      repeat (6) @(negedge clk);
      chk({31'h0, pend}, 32'h1);
      wait_pend(1'b0);
      // map drained of traffic before clearing classes
      lup = 1'b0;
      wr(BASE + 32'h14, 4'h1, 32'h00000000);
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      chk({17'h0, pend, tcm, port_arbitration_select, channel_arbitration_select}, {17'h0, 1'b1, 8'hFF, 6'h00});
      rd(BASE + 32'h14, 32'h800000FF);
      finish_test();
   end
endmodule // testbench
